// file: dv/iox_i2c_master.sv
module iox_i2c_master (
  // clock and device drive
  input  wire logic sys_clk_in,
  input  wire logic sda_oe_in,
  // bus lines
  output logic      scl_out,
  output logic      sda_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic sda_drv; // own level, one = released
  int   slow;    // extra low-phase cycles
  // wired-and with the pull-up
  assign sda_out = sda_drv & ~sda_oe_in;
  initial begin
    scl_out = 1'b1;
    sda_drv = 1'b1;
    slow    = 0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge sys_clk_in);
  endtask : wt
  // ----------------
  // bus conditions
  // ----------------
  // long first wait lets the slave drop its ack first
  task automatic start();
    sda_drv = 1'b1;
    wt(6);
    scl_out = 1'b1;
    wt(4);
    sda_drv = 1'b0;
    wt(4);
    scl_out = 1'b0;
  endtask : start
  task automatic stop();
    sda_drv = 1'b0;
    wt(6);
    scl_out = 1'b1;
    wt(4);
    sda_drv = 1'b1;
    wt(4);
  endtask : stop
  // one 400 ns bit, sampled late in the high phase
  task automatic bit_x(input logic b, output logic r);
    wt(3 + slow);
    sda_drv = b;
    wt(1);
    scl_out = 1'b1;
    wt(4);
    r = sda_out;
    scl_out = 1'b0;
  endtask : bit_x
  // msb first; d of all ones releases sda for reads
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q,
                      output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], q[i]);
    end
    bit_x(a, ack);
  endtask : xfer
endmodule : iox_i2c_master

// file: dv/iox_properties.sv
module iox_properties (
  // clock and resets
  input wire logic       sys_clk_in,
  input wire logic       reset_in,
  input wire logic       reset_n_in,
  // serial bus
  input wire logic       scl_in,
  input wire logic       sda_out,
  input wire logic       sda_oe_out,
  // parallel port and interrupt
  input wire logic [7:0] port_pin_in,
  input wire logic [7:0] port_pin_out,
  input wire logic [7:0] port_pin_oe_out,
  input wire logic       int_n_out,
  input wire logic       int_n_oe_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------
  // bus, port and interrupt checks
  // ----------------
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (reset_in);

  // defaults seen on the first edge after release
  chk_reset_vals: assert property (
    $fell(reset_in) |-> port_pin_oe_out == 8'h00 && port_pin_out == 8'hFF
      && !sda_oe_out && !int_n_oe_out)
    else $error("outputs not at defaults after reset");
  // pin reset needs two sync edges, so three low samples
  chk_pin_reset: assert property (
    !reset_n_in [*3] |=> port_pin_oe_out == 8'h00 && port_pin_out == 8'hFF)
    else $error("reset pin did not restore port");
  // open drain outputs only ever pull low
  chk_open_drain: assert property (
    sda_out == 1'b0 && int_n_out == 1'b0)
    else $error("open drain level not low");
  // an input change with all pins as inputs must flag;
  // a pin reset flips the port to inputs but holds the flag low
  chk_int_rise: assert property (disable iff (reset_in || !reset_n_in)
    $changed(port_pin_in) && port_pin_oe_out == 8'h00 && !int_n_oe_out
      |-> ##[2:6] int_n_oe_out)
    else $error("input change raised no interrupt");
  // outputs only: nothing may raise the flag
  chk_out_quiet: assert property (
    port_pin_oe_out == 8'hFF [*8] |-> !$rose(int_n_oe_out))
    else $error("output pins raised interrupt");
  // data or ack driven only after scl went low
  chk_sda_lowphase: assert property (
    $rose(sda_oe_out) |-> !$past(scl_in, 2))
    else $error("sda driven during scl high");
  // latch moves only on the acked data byte
  chk_latch_ack: assert property (disable iff (reset_in || !reset_n_in)
    $changed(port_pin_out) |-> sda_oe_out || $past(sda_oe_out))
    else $error("latch changed outside data ack");
  chk_dir_ack: assert property (disable iff (reset_in || !reset_n_in)
    $changed(port_pin_oe_out) |-> sda_oe_out || $past(sda_oe_out))
    else $error("direction changed outside data ack");
  // long scl high means start, stop or idle: sda released
  chk_release_idle: assert property (
    scl_in [*8] |-> !sda_oe_out)
    else $error("sda held while bus idle");
endmodule : iox_properties

bind iox_top iox_properties chk (
  .sys_clk_in(sys_clk_in), .reset_in(reset_in), .reset_n_in(reset_n_in),
  .scl_in(scl_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
  .port_pin_in(port_pin_in), .port_pin_out(port_pin_out),
  .port_pin_oe_out(port_pin_oe_out), .int_n_out(int_n_out), .int_n_oe_out(int_n_oe_out)
);

// file: dv/tb_i2c_eight_bit_io_expander_regs.sv
module tb_i2c_eight_bit_io_expander_regs;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------
  // signals
  // ----------------
  logic       clk   = 1'b0;   // 20 MHz
  logic       rst   = 1'b1;   // sync reset
  logic       rst_n = 1'b1;   // device reset pin
  logic       strap = 1'b0;   // address strap
  logic [7:0] ext   = 8'h3C;  // far-side pin levels
  logic [6:0] dev_a = 7'h20;  // address in use
  logic [7:0] rd;             // byte read back
  logic       ak;             // zero = ack
  int         errors       = 0;
  int         total_checks = 0;
  int         cycles       = 0;
  wire        scl;
  wire        sda;
  wire        sda_oe;
  wire        int_oe;
  wire  [7:0] pin_in;
  wire  [7:0] pin_out;
  wire  [7:0] pin_oe;
  always #25 clk = ~clk;
  // driven bits follow the latch, others the far side
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
  iox_top dut (
    .sys_clk_in(clk), .reset_in(rst), .reset_n_in(rst_n), .addr_strap_in(strap),
    .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe_out(sda_oe),
    .port_pin_in(pin_in), .port_pin_out(pin_out), .port_pin_oe_out(pin_oe),
    .int_n_out(), .int_n_oe_out(int_oe)
  );
  iox_i2c_master m (.sys_clk_in(clk), .sda_oe_in(sda_oe), .scl_out(scl), .sda_out(sda));
  // ----------------
  // helpers
  // ----------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask : wt
  task automatic probe(input logic [7:0] a, input logic exp);
    m.start();
    m.xfer(a, 1'b1, rd, ak);
    chk(ak, exp);
    m.stop();
  endtask : probe
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    m.start();
    m.xfer({dev_a, 1'b0}, 1'b1, rd, ak);
    m.xfer(p, 1'b1, rd, ak);
    m.xfer(d, 1'b1, rd, ak);
    chk(ak, 1'b0);
    m.stop();
  endtask : wr
  task automatic rdr(input logic [7:0] p, input logic [7:0] exp);
    m.start();
    m.xfer({dev_a, 1'b0}, 1'b1, rd, ak);
    m.xfer(p, 1'b1, rd, ak);
    m.start();
    m.xfer({dev_a, 1'b1}, 1'b1, rd, ak);
    m.xfer(8'hFF, 1'b1, rd, ak);
    chk(rd, exp);
    m.stop();
  endtask : rdr
  // read with no command: stored pointer, two bytes
  task automatic rdn(input logic [7:0] exp);
    m.start();
    m.xfer({dev_a, 1'b1}, 1'b1, rd, ak);
    m.xfer(8'hFF, 1'b0, rd, ak);
    chk(rd, exp);
    m.xfer(8'hFF, 1'b1, rd, ak);
    chk(rd, exp);
    m.stop();
  endtask : rdn
  // ----------------
  // scenarios
  // ----------------
  task automatic t_reset();
    chk(pin_oe, 8'h00);
    chk(pin_out, 8'hFF);
    probe({dev_a, 1'b1}, 1'b1);
    rdr(8'h01, 8'hFF);
    rdr(8'h02, 8'h00);
    rdr(8'h03, 8'hFF);
    $display("reset defaults done");
  endtask : t_reset
  task automatic t_port();
    wr(8'h01, 8'hA5);
    wr(8'h03, 8'h0F);
    chk(pin_oe, 8'hF0);
    chk(pin_out, 8'hA5);
    rdr(8'h03, 8'h0F);
    rdr(8'h00, 8'hAC);
    wr(8'h02, 8'h0F);
    rdr(8'h00, 8'hA3);
    wr(8'h00, 8'h55);
    rdr(8'h00, 8'hA3);
    m.slow = 3;
    rdn(8'hA3);
    m.slow = 0;
    $display("port registers done");
  endtask : t_port
  task automatic t_addr();
    strap = 1'b1;
    dev_a = 7'h21;
    wt(4);
    probe({7'h20, 1'b0}, 1'b1);
    probe({7'h22, 1'b0}, 1'b1);
    m.start();
    m.xfer({dev_a, 1'b0}, 1'b1, rd, ak);
    m.xfer(8'h01, 1'b1, rd, ak);
    m.xfer(8'h3C, 1'b1, rd, ak);
    m.xfer(8'h5A, 1'b1, rd, ak);
    chk(ak, 1'b0);
    m.stop();
    rdr(8'h01, 8'h5A);
    strap = 1'b0;
    dev_a = 7'h20;
    wt(4);
    $display("address strap done");
  endtask : t_addr
  task automatic t_int();
    wr(8'h03, 8'hFF);
    rdr(8'h00, 8'h33);
    chk(int_oe, 1'b0);
    ext = 8'h3D;
    wt(8);
    chk(int_oe, 1'b1);
    ext = 8'h3C;
    wt(8);
    chk(int_oe, 1'b0);
    ext = 8'hBC;
    wt(8);
    chk(int_oe, 1'b1);
    rdr(8'h00, 8'hB3);
    chk(int_oe, 1'b0);
    wr(8'h03, 8'h00);
    wr(8'h01, 8'hC3);
    wt(8);
    chk(int_oe, 1'b0);
    $display("interrupt done");
  endtask : t_int
  task automatic t_devrst();
    rst_n = 1'b0;
    wt(5);
    chk(pin_oe, 8'h00);
    chk(pin_out, 8'hFF);
    rst_n = 1'b1;
    wt(6);
    probe({dev_a, 1'b1}, 1'b1);
    rdr(8'h01, 8'hFF);
    $display("device reset done");
  endtask : t_devrst
  // ----------------
  // run control
  // ----------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict
  // about 6500 cycles expected; cut a hang well beyond
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      print_verdict();
    end
  end
  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    wt(6);
    t_reset();
    t_port();
    t_addr();
    t_int();
    t_devrst();
    print_verdict();
  end
endmodule : tb_i2c_eight_bit_io_expander_regs

// file: hw/iox_pkg.sv
// Function
// - address 0x20 strap low, 0x21 strap high
// - address lsb one reads, zero writes
// - byte after write address loads command pointer
// - pointer picks input, latch, polarity, direction
// - master acks for more, nack ends, release
// - read before any command byte is nacked
// - input register shows live pins, ignores writes
// - latch resets ones, drives output pins only
// - polarity bit one inverts reported input level
// - direction one is input, zero output, resets ones
// - input pin change asserts active low interrupt
// - interrupt clears on return or input read
// - low reset pin returns all state defaults
package iox_pkg;

  // ---------------------------------------------------------------
  // bus address
  // ---------------------------------------------------------------
  localparam logic [6:0] IOX_ADDR_BASE   = 7'h20;  // strap adds bit 0
  localparam int         IOX_RW_BIT      = 0;      // direction bit position
  localparam logic [3:0] IOX_BYTE_BITS   = 4'h8;   // bits per byte
  localparam logic [3:0] IOX_CNT_ZERO    = 4'h0;
  localparam logic [3:0] IOX_CNT_ONE     = 4'h1;

  // ---------------------------------------------------------------
  // register pointer values
  // ---------------------------------------------------------------
  localparam logic [1:0] IOX_PTR_INPUT   = 2'h0;   // pin_input_levels
  localparam logic [1:0] IOX_PTR_LATCH   = 2'h1;   // output_latch
  localparam logic [1:0] IOX_PTR_POL     = 2'h2;   // input_polarity_invert
  localparam logic [1:0] IOX_PTR_DIR     = 2'h3;   // pin_direction
  localparam int         IOX_PTR_SEL_HI  = 1;      // pointer select field msb

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] IOX_LATCH_RST   = 8'hFF;
  localparam logic [7:0] IOX_POL_RST     = 8'h00;
  localparam logic [7:0] IOX_DIR_RST     = 8'hFF;
  localparam logic [7:0] IOX_PTR_RST     = 8'h00;

  // ---------------------------------------------------------------
  // bus state machine
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    IOX_IDLE,
    IOX_ADDR,
    IOX_AACK,
    IOX_CMD,
    IOX_WDATA,
    IOX_WACK,
    IOX_RDATA,
    IOX_RACK,
    IOX_IGNORE
  } iox_state_t;

endpackage : iox_pkg

// file: hw/iox_top.sv
module iox_top (
  // clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       reset_in,
  // device reset pin and address strap
  input  wire logic       reset_n_in,
  input  wire logic       addr_strap_in,
  // serial bus
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_out,
  // parallel port
  input  wire logic [7:0] port_pin_in,
  output logic      [7:0] port_pin_out,
  output logic      [7:0] port_pin_oe_out,
  // interrupt, open drain
  output logic            int_n_out,
  output logic            int_n_oe_out
);

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [1:0] scl_sync_reg;     // [0] only feeds [1]
  logic [1:0] sda_sync_reg;
  logic [1:0] rstn_sync_reg;
  logic [1:0] strap_sync_reg;
  logic [7:0] pin_meta_reg;     // first stage, feeds pin_sync_reg only
  logic [7:0] pin_sync_reg;
  logic       scl_prev_reg;     // for edge detection
  logic       sda_prev_reg;

  // two flops on every outside level except reset_in before any logic looks at it
  always_ff @(posedge sys_clk_in) begin
    scl_sync_reg   <= {scl_sync_reg[0], scl_in};
    sda_sync_reg   <= {sda_sync_reg[0], sda_in};
    rstn_sync_reg  <= {rstn_sync_reg[0], reset_n_in};
    strap_sync_reg <= {strap_sync_reg[0], addr_strap_in};
    pin_meta_reg   <= port_pin_in;
    pin_sync_reg   <= pin_meta_reg;
  end

  // ---------------------------------------------------------------
  // internal reset
  // ---------------------------------------------------------------
  logic rst;                    // system reset or device reset pin low

  // pin reset holds every register at default while low
  assign rst = reset_in | ~rstn_sync_reg[1];

  // ---------------------------------------------------------------
  // bus event detection
  // ---------------------------------------------------------------
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  // previous samples of the synchronised lines
  always_ff @(posedge sys_clk_in) begin
    if (rst) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_prev_reg <= scl_sync_reg[1];
      sda_prev_reg <= sda_sync_reg[1];
    end
  end

  // data moving while clock is high marks start and stop
  assign scl_rise  =  scl_sync_reg[1] & ~scl_prev_reg;
  assign scl_fall  = ~scl_sync_reg[1] &  scl_prev_reg;
  assign bus_start =  scl_sync_reg[1] & scl_prev_reg & ~sda_sync_reg[1] & sda_prev_reg;
  assign bus_stop  =  scl_sync_reg[1] & scl_prev_reg & sda_sync_reg[1] & ~sda_prev_reg;

  // ---------------------------------------------------------------
  // registers and their view
  // ---------------------------------------------------------------
  logic [7:0] output_latch_reg;          // drives output pins
  logic [7:0] input_polarity_invert_reg; // inverts reported input levels
  logic [7:0] pin_direction_reg;         // one is input
  logic [7:0] register_pointer_reg;      // last command byte
  logic       pointer_loaded_reg;        // a command byte has been taken
  logic [7:0] pin_input_levels;          // live pins after polarity
  logic [7:0] read_byte;                 // register chosen by pointer
  logic [1:0] ptr_sel;

  // input view follows the pins whatever their direction
  assign pin_input_levels = pin_sync_reg ^ input_polarity_invert_reg;
  assign ptr_sel          = register_pointer_reg[iox_pkg::IOX_PTR_SEL_HI:0];

  // read multiplexer, only the low pointer bits choose
  always_comb begin
    if (ptr_sel == iox_pkg::IOX_PTR_INPUT) begin
      read_byte = pin_input_levels;
    end else if (ptr_sel == iox_pkg::IOX_PTR_LATCH) begin
      read_byte = output_latch_reg;                  // latch, not pins
    end else if (ptr_sel == iox_pkg::IOX_PTR_POL) begin
      read_byte = input_polarity_invert_reg;
    end else begin
      read_byte = pin_direction_reg;
    end
  end

  // ---------------------------------------------------------------
  // bus state machine
  // ---------------------------------------------------------------
  iox_pkg::iox_state_t state_reg;
  logic [3:0]          bit_cnt_reg;      // bits taken or sent in this byte
  logic [7:0]          rx_shift_reg;     // incoming byte
  logic [7:0]          tx_shift_reg;     // outgoing byte, msb first
  logic                read_dir_reg;     // current transfer reads
  logic                master_nack_reg;  // master left ack bit high
  logic                sda_oe_reg;       // pulling data low
  logic                write_strobe;     // data byte complete in write
  logic                input_read_ack;   // ack clock of input read
  logic [6:0]          own_addr;
  localparam int       IOX_RW_BIT_IDX = iox_pkg::IOX_RW_BIT;  // direction bit of address byte

  // strap picks the lowest address bit
  assign own_addr = {iox_pkg::IOX_ADDR_BASE[6:1], strap_sync_reg[1]};

  // byte complete strobes for the register and interrupt logic
  assign write_strobe   = (state_reg == iox_pkg::IOX_WDATA) & scl_fall &
                          (bit_cnt_reg == iox_pkg::IOX_BYTE_BITS);
  assign input_read_ack = (state_reg == iox_pkg::IOX_RACK) & scl_rise &
                          (ptr_sel == iox_pkg::IOX_PTR_INPUT);

  // sequencing of address, command, data and ack bits
  always_ff @(posedge sys_clk_in) begin
    if (rst) begin
      state_reg       <= iox_pkg::IOX_IDLE;
      bit_cnt_reg     <= iox_pkg::IOX_CNT_ZERO;
      rx_shift_reg    <= 8'h00;
      tx_shift_reg    <= 8'h00;
      read_dir_reg    <= 1'b0;
      master_nack_reg <= 1'b0;
      sda_oe_reg      <= 1'b0;
    end else if (bus_start) begin
      // start or repeated start from any state
      state_reg   <= iox_pkg::IOX_ADDR;
      bit_cnt_reg <= iox_pkg::IOX_CNT_ZERO;
      sda_oe_reg  <= 1'b0;
    end else if (bus_stop) begin
      state_reg  <= iox_pkg::IOX_IDLE;
      sda_oe_reg <= 1'b0;
    end else begin
      case (state_reg)
        // address and incoming bytes sample on the rising clock
        iox_pkg::IOX_ADDR, iox_pkg::IOX_CMD, iox_pkg::IOX_WDATA: begin
          if (scl_rise) begin
            rx_shift_reg <= {rx_shift_reg[6:0], sda_sync_reg[1]};
            bit_cnt_reg  <= bit_cnt_reg + iox_pkg::IOX_CNT_ONE;
          end else if (scl_fall && bit_cnt_reg == iox_pkg::IOX_BYTE_BITS) begin
            bit_cnt_reg <= iox_pkg::IOX_CNT_ZERO;
            if (state_reg == iox_pkg::IOX_ADDR) begin
              // reads are refused until a command byte exists
              if (rx_shift_reg[7:1] == own_addr &&
                  (!rx_shift_reg[IOX_RW_BIT_IDX] || pointer_loaded_reg)) begin
                read_dir_reg <= rx_shift_reg[IOX_RW_BIT_IDX];
                sda_oe_reg   <= 1'b1;
                state_reg    <= iox_pkg::IOX_AACK;
              end else begin
                state_reg <= iox_pkg::IOX_IGNORE;
              end
            end else begin
              // command and data bytes are always acknowledged
              sda_oe_reg <= 1'b1;
              state_reg  <= iox_pkg::IOX_WACK;
            end
          end
        end
        // address ack ends; read sends first bit at once
        iox_pkg::IOX_AACK: begin
          if (scl_fall) begin
            if (read_dir_reg) begin
              tx_shift_reg <= {read_byte[6:0], 1'b0};
              sda_oe_reg   <= ~read_byte[7];
              bit_cnt_reg  <= iox_pkg::IOX_CNT_ONE;
              state_reg    <= iox_pkg::IOX_RDATA;
            end else begin
              sda_oe_reg <= 1'b0;
              state_reg  <= iox_pkg::IOX_CMD;   // next byte is command
            end
          end
        end
        // write ack ends; further bytes go to the same register
        iox_pkg::IOX_WACK: begin
          if (scl_fall) begin
            sda_oe_reg <= 1'b0;
            state_reg  <= iox_pkg::IOX_WDATA;
          end
        end
        // outgoing bits change on the falling clock
        iox_pkg::IOX_RDATA: begin
          if (scl_fall) begin
            if (bit_cnt_reg == iox_pkg::IOX_BYTE_BITS) begin
              sda_oe_reg <= 1'b0;               // master drives ack
              state_reg  <= iox_pkg::IOX_RACK;
            end else begin
              sda_oe_reg   <= ~tx_shift_reg[7];
              tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
              bit_cnt_reg  <= bit_cnt_reg + iox_pkg::IOX_CNT_ONE;
            end
          end
        end
        // master ack asks for more, nack releases the line
        iox_pkg::IOX_RACK: begin
          if (scl_rise) begin
            master_nack_reg <= sda_sync_reg[1];
          end else if (scl_fall) begin
            if (master_nack_reg) begin
              sda_oe_reg <= 1'b0;
              state_reg  <= iox_pkg::IOX_IGNORE;
            end else begin
              // pointer is not advanced, same register again
              tx_shift_reg <= {read_byte[6:0], 1'b0};
              sda_oe_reg   <= ~read_byte[7];
              bit_cnt_reg  <= iox_pkg::IOX_CNT_ONE;
              state_reg    <= iox_pkg::IOX_RDATA;
            end
          end
        end
        // waits for start or stop with the line released
        default: begin
          sda_oe_reg <= 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // command pointer
  // ---------------------------------------------------------------
  // byte after an acknowledged write address; kept until replaced
  always_ff @(posedge sys_clk_in) begin
    if (rst) begin
      register_pointer_reg <= iox_pkg::IOX_PTR_RST;
      pointer_loaded_reg   <= 1'b0;
    end else if (state_reg == iox_pkg::IOX_CMD && scl_fall &&
                 bit_cnt_reg == iox_pkg::IOX_BYTE_BITS) begin
      register_pointer_reg <= rx_shift_reg;
      pointer_loaded_reg   <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // writable registers
  // ---------------------------------------------------------------
  // writes to the input view fall through and change nothing
  always_ff @(posedge sys_clk_in) begin
    if (rst) begin
      output_latch_reg          <= iox_pkg::IOX_LATCH_RST;
      input_polarity_invert_reg <= iox_pkg::IOX_POL_RST;
      pin_direction_reg         <= iox_pkg::IOX_DIR_RST;
    end else if (write_strobe) begin
      if (ptr_sel == iox_pkg::IOX_PTR_LATCH) begin
        output_latch_reg <= rx_shift_reg;
      end else if (ptr_sel == iox_pkg::IOX_PTR_POL) begin
        input_polarity_invert_reg <= rx_shift_reg;
      end else if (ptr_sel == iox_pkg::IOX_PTR_DIR) begin
        pin_direction_reg <= rx_shift_reg;
      end
    end
  end

  // ---------------------------------------------------------------
  // change detection and interrupt
  // ---------------------------------------------------------------
  logic [7:0] pin_snapshot_reg;  // levels last reported or at reset
  logic       snap_valid_reg;    // snapshot taken after reset
  logic [7:0] pin_changed;
  logic       int_active_reg;

  // snapshot taken after reset release and at each input read ack;
  // a change inside that ack clock can be lost, as accepted
  always_ff @(posedge sys_clk_in) begin
    if (rst) begin
      pin_snapshot_reg <= 8'h00;
      snap_valid_reg   <= 1'b0;
    end else if (!snap_valid_reg || input_read_ack) begin
      pin_snapshot_reg <= pin_sync_reg;
      snap_valid_reg   <= 1'b1;
    end
  end

  // only input pins compare; returning to snapshot clears by itself
  assign pin_changed = (pin_sync_reg ^ pin_snapshot_reg) & pin_direction_reg;

  // registered so the pin output cannot glitch
  always_ff @(posedge sys_clk_in) begin
    if (rst) begin
      int_active_reg <= 1'b0;
    end else begin
      int_active_reg <= snap_valid_reg & (|pin_changed);
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // open drain lines only ever pull low
  assign sda_out         = 1'b0;
  assign sda_oe_out      = sda_oe_reg;
  assign int_n_out       = 1'b0;
  assign int_n_oe_out    = int_active_reg;
  // latch drives only pins whose direction bit is zero
  assign port_pin_out    = output_latch_reg;
  assign port_pin_oe_out = ~pin_direction_reg;

endmodule : iox_top
